//--- hw/mprab_defines.vh
// Register offsets, field positions, reset values and timing for the region attribute bank
`ifndef MPRAB_DEFINES_VH
`define MPRAB_DEFINES_VH

// Register byte offsets
`define MPRAB_OFF_SELECT      8'h00
`define MPRAB_OFF_BASE        8'h04
`define MPRAB_OFF_LIMIT       8'h08
`define MPRAB_OFF_BASE_A1     8'h0C
`define MPRAB_OFF_LIMIT_A1    8'h10
`define MPRAB_OFF_BASE_A2     8'h14
`define MPRAB_OFF_LIMIT_A2    8'h18
`define MPRAB_OFF_BASE_A3     8'h1C
`define MPRAB_OFF_LIMIT_A3    8'h20
`define MPRAB_OFF_ATTR_LOW    8'h24
`define MPRAB_OFF_ATTR_HIGH   8'h28
`define MPRAB_OFF_CHECK_STAT  8'h2C

// Base register fields
`define MPRAB_ADDR_HI         31
`define MPRAB_ADDR_LO         5
`define MPRAB_SHARE_HI        4
`define MPRAB_SHARE_LO        3
`define MPRAB_PERM_HI         2
`define MPRAB_PERM_LO         1
`define MPRAB_EXEC_NEVER_BIT  0

// Limit register fields
`define MPRAB_RSVD_BIT        4
`define MPRAB_IDX_HI          3
`define MPRAB_IDX_LO          1
`define MPRAB_EN_BIT          0
`define MPRAB_LIMIT_WMASK     32'hFFFFFFEF

// Address expansion of the bound fields
`define MPRAB_BASE_FILL       5'h00
`define MPRAB_LIMIT_FILL      5'h1F

// Attribute byte format
`define MPRAB_DEVICE_NIBBLE   4'h0
`define MPRAB_SHARE_NONE      2'h0

// Reset values
`define MPRAB_RST_WORD        32'h00000000
`define MPRAB_RST_SELECT      8'h00

// Lookup latency in clock cycles
`define MPRAB_CHECK_LATENCY   1

`endif

//--- hw/mprab_bank.v
// Region descriptor and attribute bank with a registered access check
`default_nettype none
`include "mprab_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Base register acts on selected region
// - Base bits 31:5, zero-filled low bits
// - Shareability field bits 4:3 reported
// - Device memory forces shareability ignored
// - Access permission bits 2:1 checked
// - Execute-never bit 0 refuses fetch
// - Base aliases use select 7:2 with n
// - Limit aliases use select 7:2 with n
// - Limit bits 31:5 filled with 0x1F
// - Attribute index bits 3:1 picks byte
// - Limit bit 0 enables region
// - Low indirection holds attributes 0-3
// - High indirection holds attributes 4-7
// - Base and limit banked per security
// - Indirection registers banked per security
// - Select register chooses accessed region
// - Zero upper nibble means device memory
// - Non-zero upper nibble means normal memory
// - Permission breach raises management fault
module mprab_bank #(
  parameter REGION_BITS = 3
) (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        rst_i,
  // Register port
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire        reg_secure_i,
  output reg  [31:0] reg_rdata_o,
  // Access check request
  input  wire        chk_valid_i,
  input  wire [31:0] chk_addr_i,
  input  wire        chk_secure_i,
  input  wire        chk_priv_i,
  input  wire        chk_write_i,
  input  wire        chk_fetch_i,
  // Access check answer
  output reg         chk_done_o,
  output reg         chk_hit_o,
  output reg  [7:0]  chk_region_o,
  output reg         chk_fault_o,
  output reg  [7:0]  chk_attr_o,
  output reg         chk_device_o,
  output reg  [1:0]  chk_device_order_o,
  output reg  [1:0]  chk_share_o
);

  localparam NUM_REGIONS = 1 << REGION_BITS;
  localparam SLOTS       = 2 * NUM_REGIONS;

  ////////////////////////////////////////////////////////////////////////////////
  // Storage: one bank per security state, secure bank in the upper half
  // Slot index is {security, region}; the select register is banked too,
  // so each world keeps its own notion of the current region.
  // Storage is flops, not RAM: the scan below reads every slot of one bank at once.
  reg [31:0] base_mem [0:SLOTS-1];
  reg [31:0] limit_mem [0:SLOTS-1];
  reg [31:0] attr_lo_reg [0:1];
  reg [31:0] attr_hi_reg [0:1];
  reg [7:0]  select_reg [0:1];
  reg [31:0] check_stat_reg;

  // Reset sweep index
  integer i;
  // Region scan index, kept apart so each loop variable has one driver
  integer j;

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode
  // Offset map, every window but 0x2C banked by the access security state:
  //   0x00 select, upper bits read zero
  //   0x04 base and 0x08 limit of the selected region
  //   0x0C/0x10, 0x14/0x18, 0x1C/0x20 base/limit aliases 1 to 3
  //   0x24 low and 0x28 high attribute words
  //   0x2C check status, read only
  // Anything else is ignored on write and reads zero
  reg                 is_base;
  reg                 is_limit;
  reg                 is_alias;
  reg [1:0]           alias_n;
  reg [7:0]           tgt_region;
  reg                 tgt_valid;
  reg [REGION_BITS:0] tgt_slot;
  reg [7:0]           cur_select;

  // Aliases reach three regions at a time without touching the select register
  // One select write with low bits zero opens a group of four regions, so software can
  // program a whole group without rewriting the select register
  always @* begin
    is_base    = 1'b0;
    is_limit   = 1'b0;
    is_alias   = 1'b1;
    alias_n    = 2'h0;
    cur_select = select_reg[reg_secure_i];
    case (reg_addr_i)
      `MPRAB_OFF_BASE: begin
        is_base  = 1'b1;
        is_alias = 1'b0;
      end
      `MPRAB_OFF_LIMIT: begin
        is_limit = 1'b1;
        is_alias = 1'b0;
      end
      `MPRAB_OFF_BASE_A1: begin
        is_base = 1'b1;
        alias_n = 2'h1;
      end
      `MPRAB_OFF_LIMIT_A1: begin
        is_limit = 1'b1;
        alias_n  = 2'h1;
      end
      `MPRAB_OFF_BASE_A2: begin
        is_base = 1'b1;
        alias_n = 2'h2;
      end
      `MPRAB_OFF_LIMIT_A2: begin
        is_limit = 1'b1;
        alias_n  = 2'h2;
      end
      `MPRAB_OFF_BASE_A3: begin
        is_base = 1'b1;
        alias_n = 2'h3;
      end
      `MPRAB_OFF_LIMIT_A3: begin
        is_limit = 1'b1;
        alias_n  = 2'h3;
      end
      default: begin
        is_alias = 1'b0;
      end
    endcase
    // Direct windows follow the select register, aliases replace its low bits
    if (is_alias) begin
      tgt_region = {cur_select[7:2], alias_n};
    end else begin
      tgt_region = cur_select;
    end
    // Regions beyond the implemented count ignore writes and read zero
    tgt_valid = ((tgt_region >> REGION_BITS) == 8'h00);
    tgt_slot  = {reg_secure_i, tgt_region[REGION_BITS-1:0]};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes
  // Writes land at the strobe edge, so a read strobed in the next cycle
  // already sees them. Limit bit 4 is masked here rather than on read.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (i = 0; i < SLOTS; i = i + 1) begin
        base_mem[i]  <= `MPRAB_RST_WORD;
        limit_mem[i] <= `MPRAB_RST_WORD;
      end
      for (i = 0; i < 2; i = i + 1) begin
        attr_lo_reg[i] <= `MPRAB_RST_WORD;
        attr_hi_reg[i] <= `MPRAB_RST_WORD;
        select_reg[i]  <= `MPRAB_RST_SELECT;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i == `MPRAB_OFF_SELECT) begin
        select_reg[reg_secure_i] <= reg_wdata_i[7:0];
      end
      if (is_base && tgt_valid) begin
        base_mem[tgt_slot] <= reg_wdata_i;
      end
      if (is_limit && tgt_valid) begin
        limit_mem[tgt_slot] <= reg_wdata_i & `MPRAB_LIMIT_WMASK;
      end
      if (reg_addr_i == `MPRAB_OFF_ATTR_LOW) begin
        attr_lo_reg[reg_secure_i] <= reg_wdata_i;
      end
      if (reg_addr_i == `MPRAB_OFF_ATTR_HIGH) begin
        attr_hi_reg[reg_secure_i] <= reg_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads, data stand one cycle after the strobe
  // The read mux uses the same target as the writes, so a refused
  // region reads zero through every window
  reg [31:0] rdata_next;

  always @* begin
    rdata_next = `MPRAB_RST_WORD;
    if (reg_rd_i) begin
      if (reg_addr_i == `MPRAB_OFF_SELECT) begin
        rdata_next = {24'h000000, cur_select};
      end else if (is_base && tgt_valid) begin
        rdata_next = base_mem[tgt_slot];
      end else if (is_limit && tgt_valid) begin
        rdata_next = limit_mem[tgt_slot];
      end else if (reg_addr_i == `MPRAB_OFF_ATTR_LOW) begin
        rdata_next = attr_lo_reg[reg_secure_i];
      end else if (reg_addr_i == `MPRAB_OFF_ATTR_HIGH) begin
        rdata_next = attr_hi_reg[reg_secure_i];
      end else if (reg_addr_i == `MPRAB_OFF_CHECK_STAT) begin
        rdata_next = check_stat_reg;
      end
    end
  end

  // Unmapped offsets read zero; read data is zero outside the answer cycle
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `MPRAB_RST_WORD;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Region match: highest-numbered matching region wins on overlap
  reg [REGION_BITS:0] scan_slot;
  reg [31:0]          lo_bound;
  reg [31:0]          hi_bound;
  reg                 hit_next;
  reg [7:0]           region_next;
  reg [31:0]          hit_base;
  reg [31:0]          hit_limit;

  // The scan is a linear compare chain over all regions of one bank.
  // Its depth grows with the region count; far beyond eight regions a
  // pipelined or tree compare would be needed to hold timing.
  always @* begin
    hit_next    = 1'b0;
    region_next = 8'h00;
    hit_base    = `MPRAB_RST_WORD;
    hit_limit   = `MPRAB_RST_WORD;
    scan_slot   = {(REGION_BITS+1){1'b0}};
    lo_bound    = `MPRAB_RST_WORD;
    hi_bound    = `MPRAB_RST_WORD;
    for (j = 0; j < NUM_REGIONS; j = j + 1) begin
      scan_slot = {chk_secure_i, j[REGION_BITS-1:0]};
      lo_bound  = {base_mem[scan_slot][`MPRAB_ADDR_HI:`MPRAB_ADDR_LO],
                   `MPRAB_BASE_FILL};
      hi_bound  = {limit_mem[scan_slot][`MPRAB_ADDR_HI:`MPRAB_ADDR_LO],
                   `MPRAB_LIMIT_FILL};
      // Both bounds inclusive, disabled regions never match
      if (limit_mem[scan_slot][`MPRAB_EN_BIT] && (chk_addr_i >= lo_bound) &&
          (chk_addr_i <= hi_bound)) begin
        hit_next    = 1'b1;
        region_next = j[7:0];
        hit_base    = base_mem[scan_slot];
        hit_limit   = limit_mem[scan_slot];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Attribute lookup and permission check
  // Device detection looks at the upper nibble only; the lower nibble
  // of a normal byte is passed through untouched
  reg [2:0]  attr_idx;
  reg [31:0] attr_word;
  reg [7:0]  attr_next;
  reg        device_next;
  reg [1:0]  perm_field;
  reg        fault_next;
  reg [1:0]  share_next;

  always @* begin
    attr_idx  = hit_limit[`MPRAB_IDX_HI:`MPRAB_IDX_LO];
    // Index 0-3 from the low word, 4-7 from the high word
    if (attr_idx[2]) begin
      attr_word = attr_hi_reg[chk_secure_i];
    end else begin
      attr_word = attr_lo_reg[chk_secure_i];
    end
    attr_next   = attr_word[{attr_idx[1:0], 3'h0} +: 8];
    device_next = (attr_next[7:4] == `MPRAB_DEVICE_NIBBLE);
    // Sharing domain means nothing for device memory, so report none
    if (device_next) begin
      share_next = `MPRAB_SHARE_NONE;
    end else begin
      share_next = hit_base[`MPRAB_SHARE_HI:`MPRAB_SHARE_LO];
    end
    perm_field = hit_base[`MPRAB_PERM_HI:`MPRAB_PERM_LO];
    // No background map: an access that matches no region faults.
    // Otherwise the first breach found faults the access:
    //   unprivileged use of a privileged-only region,
    //   a write to a read-only region,
    //   a fetch from an execute-never region.
    // Fetch needs read permission too, which the privilege test covers.
    fault_next = 1'b0;
    if (!hit_next) begin
      fault_next = 1'b1;
    end else if (!chk_priv_i && !perm_field[0]) begin
      fault_next = 1'b1;
    end else if (chk_write_i && perm_field[1]) begin
      fault_next = 1'b1;
    end else if (chk_fetch_i && hit_base[`MPRAB_EXEC_NEVER_BIT]) begin
      fault_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Check answer, one cycle after the request, held until the next request
  // Results are held between requests so a slow consumer can take them late;
  // only the done pulse marks a fresh answer
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      chk_done_o         <= 1'b0;
      chk_hit_o          <= 1'b0;
      chk_region_o       <= 8'h00;
      chk_fault_o        <= 1'b0;
      chk_attr_o         <= 8'h00;
      chk_device_o       <= 1'b0;
      chk_device_order_o <= 2'h0;
      chk_share_o        <= 2'h0;
      check_stat_reg     <= `MPRAB_RST_WORD;
    end else begin
      chk_done_o <= chk_valid_i;
      if (chk_valid_i) begin
        chk_hit_o          <= hit_next;
        chk_region_o       <= region_next;
        chk_fault_o        <= fault_next;
        chk_attr_o         <= attr_next;
        chk_device_o       <= device_next;
        chk_device_order_o <= device_next ? attr_next[3:2] : 2'h0;
        chk_share_o        <= share_next;
        // Software sees the outcome of the most recent check:
        //   [31:24] attribute byte, [17:16] sharing domain,
        //   [15:8] region, [2] device, [1] fault, [0] hit
        // A miss still reports the byte of index 0; ignore it when hit is low
        check_stat_reg <= {attr_next, 6'h00, share_next, region_next,
                           5'h00, device_next, fault_next, hit_next};
      end
    end
  end

endmodule

`default_nettype wire

//--- bench/mprab_core_side.sv
// Processor-side requester that asks the bank to check one access at a time
`default_nettype none
module mprab_core_side (
  // Clock
  input  wire logic        sys_clk_i,
  // Check request toward the bank
  output var  logic        req_valid_o = 1'b0,
  output var  logic [31:0] req_addr_o = 32'h0,
  output var  logic [3:0]  req_flags_o = 4'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  // One request cycle; flags are secure, privileged, write, fetch
  task automatic issue(input logic [31:0] a, input logic [3:0] f);
    @(posedge sys_clk_i);
    req_valid_o <= 1'b1;
    req_addr_o  <= a;
    req_flags_o <= f;
    @(posedge sys_clk_i);
    req_valid_o <= 1'b0;
    // Idle bus shows junk so a stale address can never look valid
    req_addr_o  <= ~a;
    req_flags_o <= ~f;
    #1;
  endtask
endmodule
`default_nettype wire

//--- bench/mprab_bank_asserts.sv
// Concurrent port checks for the region attribute bank
`default_nettype none
module mprab_bank_asserts #(
  parameter int REGION_BITS = 3
) (
  // Clock, reset and register port
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_secure_i,
  input wire logic [31:0] reg_rdata_o,
  // Check port
  input wire logic        chk_valid_i,
  input wire logic [31:0] chk_addr_i,
  input wire logic        chk_secure_i,
  input wire logic        chk_priv_i,
  input wire logic        chk_write_i,
  input wire logic        chk_fetch_i,
  input wire logic        chk_done_o,
  input wire logic        chk_hit_o,
  input wire logic [7:0]  chk_region_o,
  input wire logic        chk_fault_o,
  input wire logic [7:0]  chk_attr_o,
  input wire logic        chk_device_o,
  input wire logic [1:0]  chk_device_order_o,
  input wire logic [1:0]  chk_share_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Check answer timing and result relations
  chk_done_follows: assert property (chk_valid_i |=> chk_done_o)
    else $error("done missing after request");
  chk_done_alone: assert property (!chk_valid_i |=> !chk_done_o)
    else $error("done without request");
  chk_miss_fault: assert property (chk_done_o && !chk_hit_o |-> chk_fault_o)
    else $error("miss without fault");
  chk_results_hold: assert property (!chk_valid_i |=>
    $stable(chk_hit_o) && $stable(chk_attr_o))
    else $error("results moved without request");
  chk_device_share: assert property (chk_done_o && chk_device_o |-> chk_share_o == 2'h0)
    else $error("device share not ignored");
  chk_device_nibble: assert property (chk_done_o |->
    chk_device_o == (chk_attr_o[7:4] == 4'h0))
    else $error("device flag wrong");
  chk_order_field: assert property (chk_done_o |->
    chk_device_order_o == (chk_device_o ? chk_attr_o[3:2] : 2'h0))
    else $error("device order wrong");
  // Register read port
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  chk_limit_rsvd: assert property (reg_rd_i && reg_addr_i == 8'h08 |=> !reg_rdata_o[4])
    else $error("reserved limit bit set");
  chk_select_width: assert property (reg_rd_i && reg_addr_i == 8'h00 |=>
    reg_rdata_o[31:8] == 24'h0)
    else $error("select upper bits set");
  cover property (chk_done_o && chk_hit_o && !chk_fault_o);
  cover property (chk_done_o && chk_fault_o);
  cover property (chk_done_o && chk_device_o);
endmodule
bind mprab_bank mprab_bank_asserts #(.REGION_BITS(REGION_BITS)) mprab_bank_asserts_i (
  .sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_secure_i,
  .reg_rdata_o, .chk_valid_i, .chk_addr_i, .chk_secure_i, .chk_priv_i, .chk_write_i,
  .chk_fetch_i, .chk_done_o, .chk_hit_o, .chk_region_o, .chk_fault_o, .chk_attr_o,
  .chk_device_o, .chk_device_order_o, .chk_share_o);
`default_nettype wire

//--- bench/mprab_bank_tb_top.sv
// Self-checking bench for the region attribute bank
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module mprab_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        reg_secure_i = 1'b0;
  logic [31:0] reg_rdata_o, chk_addr_i;
  logic        chk_valid_i, chk_done_o, chk_hit_o, chk_fault_o, chk_device_o;
  logic [3:0]  flags;
  logic [7:0]  chk_region_o, chk_attr_o, n;
  logic [1:0]  chk_device_order_o, chk_share_o;
  logic [31:0] attr_low = 32'h0844_0400;
  int          bad_count = 0;
  int          checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Design and processor-side requester
  mprab_bank #(.REGION_BITS(3)) mprab_bank_i (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_secure_i, .reg_rdata_o, .chk_valid_i, .chk_addr_i,
    .chk_secure_i(flags[3]), .chk_priv_i(flags[2]), .chk_write_i(flags[1]),
    .chk_fetch_i(flags[0]), .chk_done_o, .chk_hit_o, .chk_region_o, .chk_fault_o,
    .chk_attr_o, .chk_device_o, .chk_device_order_o, .chk_share_o);
  mprab_core_side mprab_core_side_i (.sys_clk_i, .req_valid_o(chk_valid_i),
    .req_addr_o(chk_addr_i), .req_flags_o(flags));
  // 250 MHz clock
  always #2 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////////////////////
  // Register bus cycles; strobes last one cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s);
    @(posedge sys_clk_i);
    reg_addr_i   <= a;
    reg_wdata_i  <= d;
    reg_secure_i <= s;
    reg_wr_i     <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i     <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic s, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i   <= a;
    reg_secure_i <= s;
    reg_rd_i     <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i     <= 1'b0;
    #1 `CHK("rdata", e, reg_rdata_o)
  endtask
  // One access check; region 4+k covers k*0x1000 and uses attribute byte k
  task automatic ck(input logic [31:0] a, input logic [3:0] f, input logic [1:0] e);
    logic [7:0] at;
    at = 8'(attr_low >> (8 * a[15:12]));
    mprab_core_side_i.issue(a, f);
    `CHK("done", 1'b1, chk_done_o)
    `CHK("hit", e[1], chk_hit_o)
    `CHK("fault", e[0], chk_fault_o)
    if (e[1]) begin
      `CHK("region", 8'h04 + 8'(a[15:12]), chk_region_o)
      `CHK("attr", at, chk_attr_o)
      `CHK("device", at[7:4] == 4'h0, chk_device_o)
      `CHK("order", at[7:4] == 4'h0 ? at[3:2] : 2'h0, chk_device_order_o)
      `CHK("share", at[7:4] == 4'h0 ? 2'h0 : 2'h2, chk_share_o)
    end
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    bad_count++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(8'h04, 1'b1, 32'h0);
    rd(8'hFC, 1'b1, 32'h0);
    wr(8'h00, 32'hFFFF_FF04, 1'b1);
    rd(8'h00, 1'b1, 32'h04);
    // Aliases land on regions 5..7; limit bit 4 is written set on purpose
    for (n = 1; n < 4; n++) begin
      wr(8'h04 + 8'h08 * n, 32'h1000 * n | 32'h17, 1'b1);
      wr(8'h08 + 8'h08 * n, 32'h1000 * n | 32'hFF1 | 2 * n, 1'b1);
    end
    for (n = 1; n < 4; n++) begin
      wr(8'h00, 32'h4 + n, 1'b1);
      rd(8'h04, 1'b1, 32'h1000 * n | 32'h17);
      rd(8'h08, 1'b1, 32'h1000 * n | 32'hFE1 | 2 * n);
    end
    // Alias reads replace the low select bits
    rd(8'h1C, 1'b1, 32'h3017);
    rd(8'h18, 1'b1, 32'h2FE5);
    // Region 13 is not implemented: the write must not wrap onto region 5
    wr(8'h00, 32'hD, 1'b0);
    wr(8'h04, 32'hFFE0, 1'b0);
    rd(8'h04, 1'b0, 32'h0);
    wr(8'h00, 32'h5, 1'b0);
    rd(8'h04, 1'b0, 32'h0);
    wr(8'h24, attr_low, 1'b1);
    rd(8'h24, 1'b0, 32'h0);
    rd(8'h24, 1'b1, attr_low);
    wr(8'h28, 32'hA55A_0FF0, 1'b1);
    rd(8'h28, 1'b1, 32'hA55A_0FF0);
    wr(8'h14, 32'h2010, 1'b1);
    // Flags: secure, privileged, write, fetch
    ck(32'h1000, 4'hC, 2'b10);
    ck(32'h1000, 4'hE, 2'b11);
    ck(32'h1FFF, 4'hD, 2'b11);
    ck(32'h0FFF, 4'hC, 2'b01);
    ck(32'h2000, 4'h8, 2'b11);
    ck(32'h2000, 4'hE, 2'b10);
    ck(32'h3FFF, 4'h8, 2'b10);
    rd(8'h2C, 1'b1, 32'h0800_0705);
    ck(32'h4000, 4'hC, 2'b01);
    ck(32'h1000, 4'h4, 2'b01);
    wr(8'h20, 32'h3FF0, 1'b1);
    ck(32'h3000, 4'hC, 2'b01);
    // Index 4 takes its byte from the high word
    wr(8'h18, 32'h2FE9, 1'b1);
    mprab_core_side_i.issue(32'h2000, 4'hC);
    `CHK("attr_high", 8'hF0, chk_attr_o)
    `CHK("share_normal", 2'h2, chk_share_o)
    `CHK("fault_priv", 1'b0, chk_fault_o)
    close_out();
  end
endmodule
`default_nettype wire
